// file: rtl/ebc_top.sv
// External bus controller: mode registers, software reset, protection and bus cycle engine.
//
// Behaviour
// [RQ1] Mode field: 00 single-chip, 01 expansion, 11 microprocessor; 10 is never stored.
// [RQ2] Hardware reset loads mode 00 or 11 from the boot mode pin.
// [RQ3] Writing one to the soft reset bit resets the block; it reads zero.
// [RQ4] Soft reset keeps the processor mode field.
// [RQ5] Strobe scheme bit picks read/lane/write or read/low/high write strobes in bus modes.
// [RQ6] Address width bit clear drives lines 16 to 19; set returns them to port use.
// [RQ7] Bus clock disable bit set leaves the bus clock pin undriven.
// [RQ8] Mode register writes take effect only while the protect enable bit is one.
// [RQ9] Area switch bit moves chip select 2 base from 08000h to 10000h.
// [RQ10] Internal wait bit adds one wait to internal accesses.
// [RQ11] Software using internal wait must clear area wait bits for external areas.
// [RQ12] Expansion bit reserves external 04000h-07FFFh and 80000h upward; here 80000h upward is reserved in expansion mode only.
// [RQ13] After leaving single-chip mode the address pins stay unknown until an external access.
// [RQ14] Bus width pin high gives 8-bit data, low 16-bit; held constant.
// [RQ15] Chip select pins work only when enabled; only select 0 after reset.
// [RQ16] Area wait bit clear adds a wait and enables the ready input.
// [RQ17] Low/high scheme: read low reads; low and high writes pick byte lanes.
// [RQ18] Single-write scheme: lane enable with A0 picks lanes; 8-bit uses read and write only.
// [RQ19] An address latch pulse marks the address of each external cycle.
// [RQ20] Ready low at the last falling bus clock edge inserts a wait.
// [RQ21] During a ready wait all bus outputs hold their values.
// [RQ22] Each further falling edge with ready low adds a wait; high resumes.
// [RQ23] No-wait area: read 1, write 2 bus clocks; with wait: 2 bus clocks.
// [RQ24] Takeover request low enters hold after the current access, acknowledge low.
// [RQ25] Cycles start on bus clock edges: latch pulse, then chip select, then strobes; here select and strobes start together on the falling edge.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ebc_top
  import ebc_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [15:0] REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [7:0]  REG_RDATA_O,
  input  wire logic        ACC_REQ_I,
  input  wire logic [19:0] ACC_ADDR_I,
  input  wire logic        ACC_WE_I,
  input  wire logic [1:0]  ACC_BE_I,
  input  wire logic [15:0] ACC_WDATA_I,
  output logic             ACC_READY_O,
  output logic             ACC_DONE_O,
  output logic      [15:0] ACC_RDATA_O,
  output logic             SOFT_RESET_O,
  input  wire logic        BCLK_I,
  input  wire logic        BOOT_MODE_PIN_I,
  input  wire logic        BUS_WIDTH_I,
  input  wire logic        READY_N_I,
  input  wire logic        BUS_TAKEOVER_REQ_N_I,
  input  wire logic [15:0] DATA_I,
  output logic      [15:0] DATA_O,
  output logic      [1:0]  DATA_OE_O,
  output logic      [19:0] ADDR_O,
  output logic             ADDR_OE_O,
  output logic             ADDR_HI_OE_O,
  output logic      [3:0]  CHIP_SELECT_N_O,
  output logic      [3:0]  CHIP_SELECT_OE_O,
  output logic             READ_N_O,
  output logic             LOW_BYTE_STORE_N_O,
  output logic             UPPER_LANE_ENABLE_N_O,
  output logic             STROBE_OE_O,
  output logic             ADDR_LATCH_O,
  output logic             BUS_TAKEOVER_ACK_N_O,
  output logic             BCLK_O,
  output logic             BCLK_OE_O
);

  // Strobe set for one access; 8-bit bus always uses the single-write scheme.
  function automatic ebc_strobe_t strobe_set(input logic scheme, input logic bus8,
                                             input logic we, input logic [1:0] be);
    ebc_strobe_t s;
    s.rd_n = we;
    if (scheme && !bus8) begin
      s.lo_n = !(we && be[0]);                         // [RQ17]
      s.hi_n = !(we && be[1]);                         // [RQ17]
    end else begin
      s.lo_n = !we;                                    // [RQ18]
      s.hi_n = bus8 ? 1'b1 : !be[1];                   // [RQ18]
    end
    return s;
  endfunction

  // Synchronised pins.
  logic [20:0] pins_s;
  logic [15:0] data_s;
  logic        bclk_s;
  logic        boot_s;
  logic        bus8_s;
  logic        rdy_n_s;
  logic        hold_n_s;

  ebc_sync #(.W(21)) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     ({DATA_I, BCLK_I, BOOT_MODE_PIN_I, BUS_WIDTH_I, READY_N_I, BUS_TAKEOVER_REQ_N_I}),
    .q_o     (pins_s)
  );

  assign data_s   = pins_s[20:5];
  assign bclk_s   = pins_s[4];
  assign boot_s   = pins_s[3];
  assign bus8_s   = pins_s[2];                         // [RQ14]
  assign rdy_n_s  = pins_s[1];
  assign hold_n_s = pins_s[0];

  // Control registers.
  logic [1:0] mode_ff;
  logic       scheme_ff;
  logic       awidth_ff;
  logic       bclk_dis_ff;
  logic       area2_ff;
  logic       expand_ff;
  logic       iwait_ff;
  logic [7:0] selcfg_ff;
  logic [7:0] prot_ff;
  logic       soft_rst_ff;
  logic [1:0] strap_cnt_ff;
  logic [7:0] reg_rdata_ff;
  logic       any_rst;

  // Register port decode.
  logic wr_mode0;
  logic wr_mode1;
  logic wr_selcfg;
  logic wr_prot;
  logic [7:0] rd_mux;

  assign any_rst   = !RST_N_I || soft_rst_ff;
  assign wr_mode0  = REG_WR_I && (REG_ADDR_I == OFF_MODE0) && prot_ff[PROT_MODE_BIT];  // [RQ8]
  assign wr_mode1  = REG_WR_I && (REG_ADDR_I == OFF_MODE1) && prot_ff[PROT_MODE_BIT];  // [RQ8]
  assign wr_selcfg = REG_WR_I && (REG_ADDR_I == OFF_SELCFG);
  assign wr_prot   = REG_WR_I && (REG_ADDR_I == OFF_PROTECT);

  // Read view; soft reset and unassigned bits read as zero.
  assign rd_mux = (REG_ADDR_I == OFF_MODE0)   ? {bclk_dis_ff, awidth_ff, 3'h0, scheme_ff,
                                                 mode_ff} :              // [RQ3]
                  (REG_ADDR_I == OFF_MODE1)   ? {iwait_ff, 3'h0, expand_ff, 2'h0, area2_ff} :
                  (REG_ADDR_I == OFF_SELCFG)  ? selcfg_ff :
                  (REG_ADDR_I == OFF_PROTECT) ? prot_ff : 8'h00;

  // Processor mode field: set by hardware reset and strap, untouched by soft reset.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_ff      <= MODE_SINGLE;
      strap_cnt_ff <= 2'h0;
    end else begin
      if (strap_cnt_ff != 2'h3) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
      if (strap_cnt_ff == STRAP_LOAD_CNT) begin
        mode_ff <= boot_s ? MODE_MICRO : MODE_SINGLE;  // [RQ2]
      end else if (wr_mode0 && (REG_WDATA_I[1:0] != MODE_BAD)) begin
        mode_ff <= REG_WDATA_I[1:0];                   // [RQ1] [RQ4]
      end
    end
  end

  // Remaining control bits, loaded with their reset values by either reset.
  always_ff @(posedge CLK_I) begin
    if (any_rst) begin
      scheme_ff   <= 1'b0;
      awidth_ff   <= 1'b0;
      bclk_dis_ff <= 1'b0;
      area2_ff    <= 1'b0;
      expand_ff   <= 1'b0;
      iwait_ff    <= 1'b0;
      selcfg_ff   <= SELCFG_RESET;                     // [RQ15]
      prot_ff     <= PROTECT_RESET;
    end else begin
      if (wr_mode0) begin
        scheme_ff   <= REG_WDATA_I[MODE0_SCHEME_BIT];
        awidth_ff   <= REG_WDATA_I[MODE0_AWIDTH_BIT];
        bclk_dis_ff <= REG_WDATA_I[MODE0_BCLKDIS_BIT];
      end
      if (wr_mode1) begin
        area2_ff  <= REG_WDATA_I[MODE1_AREA2_BIT];
        expand_ff <= REG_WDATA_I[MODE1_EXPAND_BIT];
        iwait_ff  <= REG_WDATA_I[MODE1_IWAIT_BIT];
      end
      if (wr_selcfg) begin
        selcfg_ff <= REG_WDATA_I;
      end
      if (wr_prot) begin
        prot_ff <= REG_WDATA_I;
      end
    end
  end

  // Soft reset pulse and read data, which stands one cycle after the read strobe.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      soft_rst_ff  <= 1'b0;
      reg_rdata_ff <= 8'h00;
    end else begin
      soft_rst_ff  <= wr_mode0 && REG_WDATA_I[MODE0_SRESET_BIT];  // [RQ3]
      reg_rdata_ff <= REG_RD_I ? rd_mux : 8'h00;
    end
  end

  // Bus clock edges as seen by the system clock.
  logic bclk_d_ff;
  logic bclk_rise;
  logic bclk_fall;
  logic bus_mode;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      bclk_d_ff <= 1'b0;
    end else begin
      bclk_d_ff <= bclk_s;
    end
  end

  assign bclk_rise = bclk_s && !bclk_d_ff;
  assign bclk_fall = !bclk_s && bclk_d_ff;
  assign bus_mode  = (mode_ff == MODE_EXPAND) || (mode_ff == MODE_MICRO);

  // Request classification.
  ebc_area_t area;

  ebc_area_dec u_dec (
    .addr_i   (ACC_ADDR_I),
    .mode_i   (mode_ff),
    .area2_i  (area2_ff),                              // [RQ9]
    .expand_i (expand_ff),                             // [RQ12]
    .area_o   (area)
  );

  // Bus cycle engine state.
  ebc_state_t  st_ff;
  logic [19:0] pin_addr_ff;
  logic [15:0] dout_ff;
  logic [1:0]  dout_oe_ff;
  logic        we_ff;
  logic [1:0]  be_ff;
  logic [3:0]  cs_sel_ff;
  logic [1:0]  rem_ff;
  logic        rdy_use_ff;
  logic        ale_ff;
  logic [3:0]  cs_n_ff;
  ebc_strobe_t strb_ff;
  logic        ack_n_ff;
  logic        done_ff;
  logic [15:0] rdata_ff;

  // Cycle length and ready use for the selected area.
  logic        area_nowait;
  logic [1:0]  ext_rem;
  logic [15:0] lane_data;

  assign area_nowait = |(area.cs_sel & selcfg_ff[7:4]);                    // [RQ16]
  assign ext_rem     = (area_nowait && !ACC_WE_I) ? REM_ONE : REM_TWO;     // [RQ23]
  assign lane_data   = (bus8_s && ACC_BE_I[1]) ? {8'h00, ACC_WDATA_I[15:8]} : ACC_WDATA_I;
  assign ACC_READY_O = (st_ff == ST_IDLE) && hold_n_s && !soft_rst_ff;

  // One step of the bus cycle per bus clock edge.
  always_ff @(posedge CLK_I) begin
    if (any_rst) begin
      st_ff       <= ST_IDLE;
      pin_addr_ff <= 20'h00000;
      dout_ff     <= 16'h0000;
      dout_oe_ff  <= 2'h0;
      we_ff       <= 1'b0;
      be_ff       <= 2'h0;
      cs_sel_ff   <= 4'h0;
      rem_ff      <= 2'h0;
      rdy_use_ff  <= 1'b0;
      ale_ff      <= 1'b0;
      cs_n_ff     <= 4'hF;
      strb_ff     <= 3'h7;
      ack_n_ff    <= 1'b1;
      done_ff     <= 1'b0;
      rdata_ff    <= 16'h0000;
    end else begin
      done_ff <= 1'b0;
      unique case (st_ff)
        ST_IDLE: begin
          if (!hold_n_s) begin
            st_ff    <= ST_HOLD;                       // [RQ24]
            ack_n_ff <= 1'b0;
          end else if (ACC_REQ_I) begin
            we_ff      <= ACC_WE_I;
            be_ff      <= ACC_BE_I;
            cs_sel_ff  <= area.cs_sel;
            rem_ff     <= area.internal ? {1'b0, iwait_ff} : ext_rem;  // [RQ10] [RQ23]
            rdy_use_ff <= !area_nowait;                // [RQ16]
            if (area.external) begin
              pin_addr_ff <= ACC_ADDR_I;               // [RQ13]
              dout_ff     <= lane_data;
              st_ff       <= ST_LATCH;
            end else if (area.internal) begin
              st_ff <= ST_INT;
            end else begin
              rdata_ff <= 16'h0000;
              done_ff  <= 1'b1;                        // [RQ12]
            end
          end
        end
        ST_LATCH: begin
          if (bclk_rise) begin
            ale_ff     <= 1'b1;                        // [RQ19] [RQ25]
            dout_oe_ff <= we_ff ? {!bus8_s, 1'b1} : 2'h0;
            st_ff      <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (bclk_fall) begin
            ale_ff  <= 1'b0;
            cs_n_ff <= ~cs_sel_ff;                     // [RQ25]
            strb_ff <= strobe_set(scheme_ff, bus8_s, we_ff, be_ff);  // [RQ5]
            st_ff   <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (bclk_rise) begin
            if (rem_ff == 2'h0) begin
              cs_n_ff    <= 4'hF;
              strb_ff    <= 3'h7;
              dout_oe_ff <= 2'h0;
              rdata_ff   <= bus8_s ? {data_s[7:0], data_s[7:0]} : data_s;
              done_ff    <= 1'b1;
              st_ff      <= ST_IDLE;
            end else begin
              rem_ff <= rem_ff - 2'h1;
            end
          end else if (bclk_fall && (rem_ff == 2'h0) && rdy_use_ff && !rdy_n_s) begin
            st_ff <= ST_RDYW;                          // [RQ20] [RQ21]
          end
        end
        ST_RDYW: begin
          if (bclk_fall && rdy_n_s) begin
            st_ff <= ST_STROBE;                        // [RQ22]
          end
        end
        ST_INT: begin
          if (bclk_rise) begin
            if (rem_ff == 2'h0) begin
              rdata_ff <= 16'h0000;
              done_ff  <= 1'b1;
              st_ff    <= ST_IDLE;
            end else begin
              rem_ff <= rem_ff - 2'h1;                 // [RQ10]
            end
          end
        end
        ST_HOLD: begin
          if (hold_n_s) begin
            ack_n_ff <= 1'b1;
            st_ff    <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drive; the bus floats in hold and outside the bus modes.
  logic bus_drv;

  assign bus_drv               = bus_mode && (st_ff != ST_HOLD);
  assign REG_RDATA_O           = reg_rdata_ff;
  assign ACC_DONE_O            = done_ff;
  assign ACC_RDATA_O           = rdata_ff;
  assign SOFT_RESET_O          = soft_rst_ff;
  assign DATA_O                = dout_ff;
  assign DATA_OE_O             = bus_drv ? dout_oe_ff : 2'h0;
  assign ADDR_O                = pin_addr_ff;
  assign ADDR_OE_O             = bus_drv;
  assign ADDR_HI_OE_O          = bus_drv && !awidth_ff;                    // [RQ6]
  assign CHIP_SELECT_N_O       = cs_n_ff;
  assign CHIP_SELECT_OE_O      = bus_drv ? selcfg_ff[3:0] : 4'h0;          // [RQ15]
  assign READ_N_O              = strb_ff.rd_n;
  assign LOW_BYTE_STORE_N_O    = strb_ff.lo_n;
  assign UPPER_LANE_ENABLE_N_O = strb_ff.hi_n;
  assign STROBE_OE_O           = bus_drv;
  assign ADDR_LATCH_O          = ale_ff;
  assign BUS_TAKEOVER_ACK_N_O  = ack_n_ff;
  assign BCLK_O                = bclk_d_ff;
  assign BCLK_OE_O             = bus_mode && !bclk_dis_ff;                 // [RQ7]

endmodule // ebc_top
`default_nettype wire

// file: rtl/ebc_pkg.sv
// Package with register map, field layout, memory map and types of the external bus controller.
package ebc_pkg;

  // Register offsets on the plain register port.
  localparam logic [15:0] OFF_MODE0   = 16'h0004;
  localparam logic [15:0] OFF_MODE1   = 16'h0005;
  localparam logic [15:0] OFF_SELCFG  = 16'h0008;
  localparam logic [15:0] OFF_PROTECT = 16'h000A;

  // Field positions.
  localparam int MODE0_SCHEME_BIT  = 2;
  localparam int MODE0_SRESET_BIT  = 3;
  localparam int MODE0_AWIDTH_BIT  = 6;
  localparam int MODE0_BCLKDIS_BIT = 7;
  localparam int MODE1_AREA2_BIT   = 0;
  localparam int MODE1_EXPAND_BIT  = 3;
  localparam int MODE1_IWAIT_BIT   = 7;
  localparam int PROT_MODE_BIT     = 1;

  // Values after reset.
  localparam logic [7:0] SELCFG_RESET  = 8'h01;
  localparam logic [7:0] PROTECT_RESET = 8'h00;
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;

  // Processor mode codes.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_EXPAND = 2'h1;
  localparam logic [1:0] MODE_BAD    = 2'h2;
  localparam logic [1:0] MODE_MICRO  = 2'h3;

  // Memory map boundaries.
  localparam logic [19:0] RAM_END      = 20'h03FFF;
  localparam logic [19:0] RSV_LO_BASE  = 20'h04000;
  localparam logic [19:0] RSV_LO_END   = 20'h07FFF;
  localparam logic [19:0] CS2_BASE_OFF = 20'h08000;
  localparam logic [19:0] CS2_BASE_ON  = 20'h10000;
  localparam logic [19:0] CS2_END      = 20'h26FFF;
  localparam logic [19:0] CS1_END      = 20'h2FFFF;
  localparam logic [19:0] RSV_HI_BASE  = 20'h80000;
  localparam logic [19:0] ROM_BASE     = 20'hD0000;

  // Remaining bus-clock cycles after the strobe edge.
  localparam logic [1:0] REM_ONE = 2'h0;
  localparam logic [1:0] REM_TWO = 2'h1;

  // Bus cycle states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LATCH  = 3'b001,
    ST_ADDR   = 3'b010,
    ST_STROBE = 3'b011,
    ST_RDYW   = 3'b100,
    ST_INT    = 3'b101,
    ST_HOLD   = 3'b110
  } ebc_state_t;

  // Read and write strobe set, all active low.
  typedef struct packed {
    logic rd_n;
    logic lo_n;
    logic hi_n;
  } ebc_strobe_t;

  // Outcome of the address decoder.
  typedef struct packed {
    logic       internal;
    logic       external;
    logic       reserved;
    logic [3:0] cs_sel;
  } ebc_area_t;

endpackage

// file: rtl/ebc_sync.sv
// Two-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module ebc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule // ebc_sync
`default_nettype wire

// file: rtl/ebc_area_dec.sv
// Address decoder that sorts an access into internal, external or reserved space.
`timescale 1ns/10ps
`default_nettype none
module ebc_area_dec
  import ebc_pkg::*;
(
  input  wire logic [19:0] addr_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        area2_i,
  input  wire logic        expand_i,
  output ebc_area_t        area_o
);

  logic in_ram;
  logic in_lo;
  logic in_blk;
  logic in_rom;
  logic in_cs2;
  logic in_cs1;
  logic is_int;
  logic is_rsv;

  // Region hits; the lower block belongs to chip select 2 only when the switch is clear.
  assign in_ram = addr_i <= RAM_END;
  assign in_lo  = (addr_i >= RSV_LO_BASE) && (addr_i <= RSV_LO_END);
  assign in_blk = area2_i && (addr_i >= CS2_BASE_OFF) && (addr_i < CS2_BASE_ON);
  assign in_rom = (addr_i >= ROM_BASE) && (mode_i != MODE_MICRO);
  assign in_cs2 = (addr_i >= (area2_i ? CS2_BASE_ON : CS2_BASE_OFF)) && (addr_i <= CS2_END);
  assign in_cs1 = (addr_i > CS2_END) && (addr_i <= CS1_END);

  // The expansion bit gives the low window to internal memory and, in expansion mode only, reserves the high range.
  assign is_int = in_ram || in_rom || (in_blk && (mode_i != MODE_MICRO)) || (expand_i && in_lo);
  assign is_rsv = !is_int && ((mode_i == MODE_SINGLE) ||
                  (expand_i && (mode_i == MODE_EXPAND) && (addr_i >= RSV_HI_BASE)));

  // One chip select per external area.
  assign area_o.internal = is_int;
  assign area_o.reserved = is_rsv;
  assign area_o.external = !is_int && !is_rsv;
  assign area_o.cs_sel   = (is_int || is_rsv) ? 4'h0 :
                           in_lo  ? 4'h8 :
                           in_cs2 ? 4'h4 :
                           in_cs1 ? 4'h2 : 4'h1;

endmodule // ebc_area_dec
`default_nettype wire

// file: dv/ebc_top_monitor.sv
// Checker of the external bus controller port behaviour.
`timescale 1ns/10ps
`default_nettype none
module ebc_top_chk
  import ebc_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [7:0]  REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [7:0]  REG_RDATA_O,
  input wire logic        SOFT_RESET_O,
  input wire logic [19:0] ADDR_O,
  input wire logic [15:0] DATA_O,
  input wire logic [3:0]  CHIP_SELECT_N_O,
  input wire logic [3:0]  CHIP_SELECT_OE_O,
  input wire logic        READ_N_O,
  input wire logic        LOW_BYTE_STORE_N_O,
  input wire logic        ADDR_OE_O,
  input wire logic        STROBE_OE_O,
  input wire logic [1:0]  DATA_OE_O,
  input wire logic        ADDR_LATCH_O,
  input wire logic        BUS_TAKEOVER_REQ_N_I,
  input wire logic        BUS_TAKEOVER_ACK_N_O
);
  // All checks run on the system clock and rest during reset.
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data outside its slot");
  a_soft_pulse: assert property (SOFT_RESET_O |=> !SOFT_RESET_O)
    else $error("soft reset pulse too long");
  a_soft_cause: assert property (SOFT_RESET_O |-> $past(REG_WR_I) &&
    $past(REG_ADDR_I) == OFF_MODE0 && ($past(REG_WDATA_I) & 8'h08) != 8'h00)
    else $error("soft reset without its write");
  a_read_hold: assert property (!READ_N_O && !$past(READ_N_O) |->
    $stable(ADDR_O) && $stable(CHIP_SELECT_N_O)) else $error("bus moved in read");
  a_write_hold: assert property (!LOW_BYTE_STORE_N_O && !$past(LOW_BYTE_STORE_N_O)
    |-> $stable(DATA_O) && $stable(ADDR_O)) else $error("bus moved in write");
  a_cs_enable: assert property ((~CHIP_SELECT_N_O & ~CHIP_SELECT_OE_O) == 4'h0)
    else $error("disabled chip select active");
  a_hold_float: assert property (!BUS_TAKEOVER_ACK_N_O |->
    !ADDR_OE_O && !STROBE_OE_O && DATA_OE_O == 2'h0) else $error("bus driven in hold");
  a_hold_exit: assert property ($rose(BUS_TAKEOVER_REQ_N_I) && !BUS_TAKEOVER_ACK_N_O
    |-> ##[1:6] BUS_TAKEOVER_ACK_N_O) else $error("hold not left");
  a_latch_first: assert property ($rose(ADDR_LATCH_O) |-> &CHIP_SELECT_N_O &&
    READ_N_O) else $error("latch pulse after select");
endmodule // ebc_top_chk

bind ebc_top ebc_top_chk i_chk (.*);
`default_nettype wire

// file: dv/ebc_mem_model.sv
// External memory on the separate bus, with a ready line that can stall.
`timescale 1ns/10ps
`default_nettype none
module ebc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        sch_i,
  input  wire logic [3:0]  stall_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [3:0]  cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        lo_n_i,
  input  wire logic        hi_n_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             ready_n_o
);
  logic [15:0] mem [16];
  logic [7:0]  cnt;
  logic        act;
  logic        wl;
  logic        wh;
  // Lane decode for both strobe schemes on a 16-bit bus.
  assign act = (cs_n_i != 4'hF) && (!rd_n_i || !lo_n_i || (sch_i && !hi_n_i));
  assign wl  = sch_i ? !lo_n_i : (!lo_n_i && !addr_i[0]);
  assign wh  = sch_i ? !hi_n_i : (!lo_n_i && !hi_n_i);
  // Ready is pulled low for stall_i bus clocks, else left high as by a pull-up.
  assign ready_n_o = !(act && cnt < 8'({stall_i, 3'h0}));
  // Stores lanes, and drives read data only while selected and read; else a moving pattern.
  always_ff @(posedge clk_i) begin
    cnt <= act ? cnt + 8'h01 : 8'h00;
    if (act && wl) mem[addr_i[4:1]][7:0] <= wdata_i[7:0];
    if (act && wh) mem[addr_i[4:1]][15:8] <= wdata_i[15:8];
    rdata_o <= (act && !rd_n_i) ? mem[addr_i[4:1]] : ~rdata_o;
  end
endmodule // ebc_mem_model
`default_nettype wire

// file: dv/ebc_top_tb_top.sv
// Self-checking testbench of the external bus controller.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module ebc_top_tb_top;
  import ebc_pkg::*;
  logic CLK_I = 0, RST_N_I = 0, REG_WR_I = 0, REG_RD_I = 0, ACC_REQ_I = 0, ACC_WE_I = 0;
  logic BCLK_I = 0, BOOT_MODE_PIN_I = 0, BUS_TAKEOVER_REQ_N_I = 1, sch = 0;
  logic [15:0] REG_ADDR_I = 0, ACC_WDATA_I = 0, DATA_I, DATA_O, ACC_RDATA_O;
  logic [7:0]  REG_WDATA_I = 0, REG_RDATA_O;
  logic [19:0] ACC_ADDR_I = 0, ADDR_O;
  logic [1:0]  ACC_BE_I = 0;
  logic [3:0]  stall = 0, cs_acc, CHIP_SELECT_N_O;
  logic ACC_READY_O, ACC_DONE_O, READY_N_I, READ_N_O, LO_N, HI_N, ACK_N, ADDR_OE_O;
  logic ADDR_HI_OE_O, BCLK_OE_O, SOFT_RESET_O;
  int n_fail = 0, n_tests = 0, n_lo, n_lo0, n_lo1;

  ebc_top i_dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .ACC_REQ_I(ACC_REQ_I), .ACC_ADDR_I(ACC_ADDR_I),
    .ACC_WE_I(ACC_WE_I), .ACC_BE_I(ACC_BE_I), .ACC_WDATA_I(ACC_WDATA_I),
    .ACC_READY_O(ACC_READY_O), .ACC_DONE_O(ACC_DONE_O), .ACC_RDATA_O(ACC_RDATA_O),
    .SOFT_RESET_O(SOFT_RESET_O), .BCLK_I(BCLK_I), .BOOT_MODE_PIN_I(BOOT_MODE_PIN_I),
    .BUS_WIDTH_I(1'b0), .READY_N_I(READY_N_I), .BUS_TAKEOVER_REQ_N_I(BUS_TAKEOVER_REQ_N_I),
    .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE_O(), .ADDR_O(ADDR_O), .ADDR_OE_O(ADDR_OE_O),
    .ADDR_HI_OE_O(ADDR_HI_OE_O), .CHIP_SELECT_N_O(CHIP_SELECT_N_O), .CHIP_SELECT_OE_O(),
    .READ_N_O(READ_N_O), .LOW_BYTE_STORE_N_O(LO_N), .UPPER_LANE_ENABLE_N_O(HI_N),
    .STROBE_OE_O(), .ADDR_LATCH_O(), .BUS_TAKEOVER_ACK_N_O(ACK_N), .BCLK_O(),
    .BCLK_OE_O(BCLK_OE_O));
  ebc_mem_model i_mem (.clk_i(CLK_I), .sch_i(sch), .stall_i(stall), .addr_i(ADDR_O),
    .cs_n_i(CHIP_SELECT_N_O), .rd_n_i(READ_N_O), .lo_n_i(LO_N), .hi_n_i(HI_N),
    .wdata_i(DATA_O), .rdata_o(DATA_I), .ready_n_o(READY_N_I));

  // System clock of 50 ns and a bus clock of 400 ns with an unrelated phase.
  initial forever #25 CLK_I = ~CLK_I;
  initial begin #37; forever #200 BCLK_I = ~BCLK_I; end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    REG_WR_I <= 1'b1; REG_ADDR_I <= a; REG_WDATA_I <= d;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge CLK_I);
    REG_RD_I <= 1'b1; REG_ADDR_I <= a;
    @(posedge CLK_I);
    REG_RD_I <= 1'b0;
    #1 `CHK(REG_RDATA_O, e)
  endtask

  // One access on the request port; records strobe length and selects seen.
  task automatic acc(input logic [19:0] a, input logic we, input logic [1:0] be,
                     input logic [15:0] wd, input logic [15:0] e);
    int i;
    logic r;
    @(posedge CLK_I);
    ACC_REQ_I <= 1'b1; ACC_ADDR_I <= a; ACC_WE_I <= we; ACC_BE_I <= be; ACC_WDATA_I <= wd;
    r = 1'b0; cs_acc = 4'hF; n_lo = 0;
    for (i = 0; i < 400 && !r; i++) begin
      @(negedge CLK_I); r = (ACC_READY_O === 1'b1); @(posedge CLK_I);
    end
    ACC_REQ_I <= 1'b0;
    r = 1'b0;
    for (i = 0; i < 400 && !r; i++) begin
      @(negedge CLK_I); r = (ACC_DONE_O === 1'b1);
      cs_acc &= CHIP_SELECT_N_O; if (!READ_N_O) n_lo++;
    end
    if (!r) `CHK(1'b0, 1'b1)
    if (!we) `CHK(ACC_RDATA_O, e)
  endtask

  task automatic rst(input logic b);
    BOOT_MODE_PIN_I <= b; RST_N_I <= 1'b0;
    repeat (3) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin #3_000_000; n_fail++; give_verdict; end

  initial begin
    rst(1'b0);
    rd(OFF_MODE0, 8'h00); rd(OFF_SELCFG, 8'h01); rd(16'h0006, 8'h00);
    wr(OFF_MODE0, 8'h01); rd(OFF_MODE0, 8'h00);
    wr(OFF_PROTECT, 8'h02); wr(OFF_MODE0, 8'h03); rd(OFF_MODE0, 8'h03);
    wr(OFF_MODE0, 8'h02); rd(OFF_MODE0, 8'h03); wr(OFF_MODE0, 8'h01); rd(OFF_MODE0, 8'h01);
    #1 `CHK({ADDR_HI_OE_O, BCLK_OE_O}, 2'b11)
    wr(OFF_MODE0, 8'hC1); #1 `CHK({ADDR_HI_OE_O, BCLK_OE_O}, 2'b00)
    $display("test modes done");
    wr(OFF_SELCFG, 8'h1F);
    for (int s = 0; s < 2; s++) begin
      sch = s[0]; wr(OFF_MODE0, s ? 8'h05 : 8'h01);
      acc(20'h30000, 1'b1, 2'b11, 16'h1234, 16'h0);
      acc(20'h30001, 1'b1, 2'b10, 16'hAB00, 16'h0);
      acc(20'h30000, 1'b1, 2'b01, 16'h00C0 + 16'(s), 16'h0);
      acc(20'h30000, 1'b0, 2'b11, 16'h0, 16'hABC0 + 16'(s));
      `CHK(cs_acc, 4'hE)
    end
    n_lo0 = n_lo; `CHK(n_lo0 <= 5, 1'b1)
    wr(OFF_SELCFG, 8'h0F); acc(20'h30000, 1'b0, 2'b11, 16'h0, 16'hABC1); n_lo1 = n_lo;
    `CHK(n_lo1 > n_lo0, 1'b1)
    stall = 4'h3; acc(20'h30000, 1'b0, 2'b11, 16'h0, 16'hABC1); stall = 4'h0;
    `CHK(n_lo > n_lo1 + 8, 1'b1)
    $display("test bus cycles done");
    acc(20'h08000, 1'b0, 2'b11, 16'h0, 16'hABC1); `CHK(cs_acc, 4'hB)
    wr(OFF_MODE1, 8'h01); acc(20'h08000, 1'b0, 2'b11, 16'h0, 16'h0); `CHK(cs_acc, 4'hF)
    wr(OFF_MODE1, 8'h08); acc(20'h80000, 1'b0, 2'b11, 16'h0, 16'h0); `CHK(cs_acc, 4'hF)
    BUS_TAKEOVER_REQ_N_I <= 1'b0; repeat (10) @(posedge CLK_I);
    `CHK({ACK_N, ADDR_OE_O}, 2'b00)
    BUS_TAKEOVER_REQ_N_I <= 1'b1; repeat (10) @(posedge CLK_I);
    `CHK(ACK_N, 1'b1)
    $display("test areas and hold done");
    wr(OFF_MODE0, 8'h09); #1 `CHK(SOFT_RESET_O, 1'b1)
    repeat (3) @(posedge CLK_I);
    rd(OFF_MODE0, 8'h01); rd(OFF_SELCFG, 8'h01); rd(OFF_PROTECT, 8'h00);
    rst(1'b1); rd(OFF_MODE0, 8'h03);
    $display("test resets done");
    give_verdict;
  end
endmodule // ebc_top_tb_top
`default_nettype wire
